/* File: include/cbmc_regs.svh */
`ifndef CBMC_REGS_SVH
`define CBMC_REGS_SVH

// register byte offsets
`define CBMC_OFF_CTRL 12'h000
`define CBMC_OFF_STAT 12'h004
`define CBMC_OFF_UVSTAT 12'h008
`define CBMC_OFF_SECOND_STATUS_REG 12'h00C
`define CBMC_OFF_SWCTRL 12'h010
`define CBMC_OFF_POLARITY 12'h014
`define CBMC_OFF_EXP1 12'h018
`define CBMC_OFF_EXPN 12'h01C
`define CBMC_OFF_AUTOUV 12'h058
`define CBMC_OFF_DLYCTRL 12'h05C
`define CBMC_OFF_EVSTAT 12'h060
`define CBMC_OFF_EVMASK 12'h064
`define CBMC_OFF_EXIT 12'h068

// field positions
`define CBMC_CTRL_MODE_LSB 0
`define CBMC_CTRL_ACTIVE_BIT 4
`define CBMC_CTRL_UNIT_LSB 8
`define CBMC_STAT_TIMER_LSB 0
`define CBMC_STAT_CNTR_LSB 16
`define CBMC_SW_RESTART_BIT 16
`define CBMC_AUTOUV_MINCELL_BIT 16
`define CBMC_DLY_NTFY_LSB 0
`define CBMC_DLY_CAL_LSB 8
`define CBMC_EV_REJECT_BIT 0
`define CBMC_EV_HEALTH_BIT 1
`define CBMC_EV_DONE_BIT 2

// reset values
`define CBMC_EXP_RST 10'h000
`define CBMC_UVTHR_RST 14'h0000

// timing
`define CBMC_CLK_HZ 200000000
`define CBMC_ALIVE_HZ 1
`define CBMC_TICK_CYCLES (`CBMC_CLK_HZ / `CBMC_ALIVE_HZ)
`define CBMC_HEALTH_CYCLES 4

`endif

/* File: include/cbmc_pkg.sv */
package cbmc_pkg;

    typedef enum logic [2:0] {
        CBMC_MODE_OFF = 3'b000,
        CBMC_MODE_EMERG = 3'b001,
        CBMC_MODE_MAN0 = 3'b010,
        CBMC_MODE_MAN1 = 3'b011,
        CBMC_MODE_AUTO_S = 3'b100,
        CBMC_MODE_AUTO_M = 3'b101,
        CBMC_MODE_AUTO_G0 = 3'b110,
        CBMC_MODE_AUTO_G1 = 3'b111
    } cbmc_mode_type;

    typedef enum logic [1:0] {
        CBMC_ST_IDLE = 2'b00,
        CBMC_ST_CHECK = 2'b01,
        CBMC_ST_RUN = 2'b10,
        CBMC_ST_DONE = 2'b11
    } cbmc_state_type;

    typedef struct packed {
        logic timer_en;
        logic uv_en;
        logic thermal_en;
    } cbmc_exit_type;

    typedef struct packed {
        logic [11:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [11:0] araddr;
        logic arvalid;
        logic rready;
    } cbmc_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } cbmc_axi_rsp_type;

endpackage

/* File: core/cbmc_top.sv */
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`include "cbmc_regs.svh"

module cbmc_top #(
    parameter int NCELL = 14,
    parameter int TICK_CYCLES = `CBMC_TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire cbmc_pkg::cbmc_axi_req_type axi_req,
    output cbmc_pkg::cbmc_axi_rsp_type axi_rsp,
    input wire logic timer_expired,
    input wire logic thermal_fault,
    input wire logic uv_reached,
    input wire logic health_fail,
    output logic [NCELL-1:0] balance_switch_on,
    output logic irq
);
    import cbmc_pkg::*;

    ////////////////////////////////////////////////////////////////
    // bus handshake
    logic aw_hold_q;
    logic w_hold_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [1:0] bresp_q;
    logic wr_fire;
    logic [31:0] wmask;
    logic [31:0] wval;
    assign axi_rsp.awready = !aw_hold_q && !bvalid_q;
    assign axi_rsp.wready = !w_hold_q && !bvalid_q;
    assign axi_rsp.arready = !rvalid_q;
    assign axi_rsp.bvalid = bvalid_q;
    assign axi_rsp.bresp = bresp_q;
    assign axi_rsp.rvalid = rvalid_q;
    assign axi_rsp.rdata = rdata_q;
    assign axi_rsp.rresp = rresp_q;
    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (axi_req.awvalid && axi_rsp.awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= axi_req.awaddr;
            end else if (wr_fire) begin
                aw_hold_q <= 1'b0;
            end
            if (axi_req.wvalid && axi_rsp.wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= axi_req.wdata;
                wstrb_q <= axi_req.wstrb;
            end else if (wr_fire) begin
                w_hold_q <= 1'b0;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{wstrb_q[i]}};
        end
    end
    assign wval = wdata_q & wmask;

    ////////////////////////////////////////////////////////////////
    // mode classes and write decode
    cbmc_mode_type mode_q;
    logic is_auto;
    logic is_man;
    logic is_emerg;
    logic wr_ctrl;
    logic wr_sw;
    logic wr_pol;
    logic wr_exp1;
    logic wr_expn;
    logic wr_auv;
    logic wr_dly;
    logic wr_evs;
    logic wr_evm;
    logic wr_exit;
    logic wr_known;
    logic [NCELL-2:0] wr_expn_sel;
    logic block_sw;
    logic block_exp1;
    logic block_expn;
    logic block_auv;
    logic block_dly;
    logic blocked;
    assign is_auto = mode_q[2];
    assign is_man = (mode_q[2:1] == 2'b01);
    assign is_emerg = (mode_q == CBMC_MODE_EMERG);
    assign wr_ctrl = wr_fire && awaddr_q == `CBMC_OFF_CTRL;
    assign wr_sw = wr_fire && awaddr_q == `CBMC_OFF_SWCTRL;
    assign wr_pol = wr_fire && awaddr_q == `CBMC_OFF_POLARITY;
    assign wr_exp1 = wr_fire && awaddr_q == `CBMC_OFF_EXP1;
    assign wr_expn = |wr_expn_sel;
    assign wr_auv = wr_fire && awaddr_q == `CBMC_OFF_AUTOUV;
    assign wr_dly = wr_fire && awaddr_q == `CBMC_OFF_DLYCTRL;
    assign wr_evs = wr_fire && awaddr_q == `CBMC_OFF_EVSTAT;
    assign wr_evm = wr_fire && awaddr_q == `CBMC_OFF_EVMASK;
    assign wr_exit = wr_fire && awaddr_q == `CBMC_OFF_EXIT;
    assign wr_known = wr_ctrl | wr_sw | wr_pol | wr_exp1 | wr_expn | wr_auv | wr_dly | wr_evs | wr_evm | wr_exit
        | (wr_fire && (awaddr_q == `CBMC_OFF_STAT || awaddr_q == `CBMC_OFF_UVSTAT
        || awaddr_q == `CBMC_OFF_SECOND_STATUS_REG));
    // whole-register blocking, off while disabled
    assign block_sw = is_auto;
    assign block_exp1 = mode_q != CBMC_MODE_OFF;
    assign block_expn = is_auto;
    assign block_auv = is_auto;
    assign block_dly = is_auto || is_emerg;
    assign blocked = (wr_sw && block_sw) || (wr_exp1 && block_exp1) || (wr_expn && block_expn)
        || (wr_auv && block_auv) || (wr_dly && block_dly);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_known ? 2'b00 : 2'b10;
        end else if (axi_req.bready) begin
            bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // configuration registers
    logic [NCELL-1:0] sw_en_q;
    logic [NCELL-1:0] polarity_q;
    logic [9:0] exp_q [NCELL];
    logic [13:0] uv_thr_q;
    logic min_cell_q;
    logic [7:0] notify_q;
    logic [7:0] cal_dly_q;
    cbmc_exit_type exit_en_q;
    logic restart_act;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_en_q <= '0;
            polarity_q <= '0;
            uv_thr_q <= `CBMC_UVTHR_RST;
            min_cell_q <= 1'b0;
            notify_q <= 8'h00;
            cal_dly_q <= 8'h00;
            exit_en_q <= 3'b111;
        end else begin
            if (wr_sw && !block_sw) begin
                sw_en_q <= wval[NCELL-1:0];
            end
            if (wr_pol) begin
                polarity_q <= wval[NCELL-1:0];
            end
            if (wr_auv && !block_auv) begin
                uv_thr_q <= wval[13:0];
                min_cell_q <= wval[`CBMC_AUTOUV_MINCELL_BIT];
            end
            if (wr_dly && !block_dly) begin
                notify_q <= wval[`CBMC_DLY_NTFY_LSB +: 8];
                cal_dly_q <= wval[`CBMC_DLY_CAL_LSB +: 8];
            end
            if (wr_exit) begin
                exit_en_q <= wval[2:0];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCELL; g++) begin : g_exp
            if (g == 0) begin : g_first
                always_ff @(posedge aclk) begin
                    if (!aresetn) begin
                        exp_q[g] <= `CBMC_EXP_RST;
                    end else if (wr_exp1 && !block_exp1) begin
                        exp_q[g] <= wval[9:0];
                    end
                end
            end else begin : g_rest
                assign wr_expn_sel[g-1] = wr_fire && awaddr_q == `CBMC_OFF_EXPN + 12'((g - 1) * 4);
                always_ff @(posedge aclk) begin
                    if (!aresetn) begin
                        exp_q[g] <= `CBMC_EXP_RST;
                    end else if (wr_expn_sel[g-1] && !block_expn) begin
                        exp_q[g] <= wval[9:0];
                    end
                end
            end
        end
    endgenerate

    // restart acts only in manual mode
    assign restart_act = wr_sw && is_man && wval[`CBMC_SW_RESTART_BIT];

    ////////////////////////////////////////////////////////////////
    // mode and sequencing
    cbmc_state_type state_q;
    logic [15:0] timer_q;
    logic [1:0] alive_q;
    logic [31:0] tick_cnt_q;
    logic tick;
    logic [2:0] hc_cnt_q;
    logic exit_met;
    logic active;
    logic mode_wr;
    assign mode_wr = wr_ctrl;
    assign active = (state_q == CBMC_ST_RUN);
    assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    // all enabled exits met; none enabled never exits
    assign exit_met = (|exit_en_q) && (!exit_en_q.timer_en || timer_expired)
        && (!exit_en_q.uv_en || uv_reached) && (!exit_en_q.thermal_en || thermal_fault);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= CBMC_MODE_OFF;
        end else if (mode_wr) begin
            mode_q <= cbmc_mode_type'(wval[`CBMC_CTRL_MODE_LSB +: 3]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= CBMC_ST_IDLE;
            hc_cnt_q <= 3'h0;
        end else if (mode_wr) begin
            state_q <= (wval[2:0] == 3'b000) ? CBMC_ST_IDLE : CBMC_ST_CHECK;
            hc_cnt_q <= 3'h0;
        end else begin
            case (state_q)
                CBMC_ST_IDLE: begin
                    state_q <= CBMC_ST_IDLE;
                end
                CBMC_ST_CHECK: begin
                    hc_cnt_q <= hc_cnt_q + 3'h1;
                    if (health_fail) begin
                        state_q <= CBMC_ST_DONE;
                    end else if (hc_cnt_q == 3'(`CBMC_HEALTH_CYCLES - 1)) begin
                        state_q <= CBMC_ST_RUN;
                    end
                end
                CBMC_ST_RUN: begin
                    if (exit_met) begin
                        state_q <= CBMC_ST_DONE;
                    end
                end
                CBMC_ST_DONE: begin
                    state_q <= CBMC_ST_DONE;
                end
                default: begin
                    state_q <= CBMC_ST_IDLE;
                end
            endcase
        end
    end

    // timer and alive counter, cleared by mode writes; timer also cleared by a manual restart while active
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_q <= 16'h0000;
            alive_q <= 2'b00;
            tick_cnt_q <= 32'h00000000;
        end else if (mode_wr) begin
            timer_q <= 16'h0000;
            alive_q <= 2'b00;
            tick_cnt_q <= 32'h00000000;
        end else if (active) begin
            tick_cnt_q <= tick ? 32'h00000000 : tick_cnt_q + 32'h00000001;
            if (restart_act) begin
                timer_q <= 16'h0000;
            end else if (tick) begin
                timer_q <= timer_q + 16'h0001;
            end
            if (tick) begin
                alive_q <= alive_q + 2'b01;
            end
        end
    end

    // switch drive, polarity_q not applied; switches held off in emergency mode
    generate
        for (g = 0; g < NCELL; g++) begin : g_sw
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    balance_switch_on[g] <= 1'b0;
                end else begin
                    balance_switch_on[g] <= active && sw_en_q[g] && !is_emerg;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // events and interrupt
    logic [2:0] ev_q;
    logic [2:0] mask_q;
    logic [2:0] ev_set;
    assign ev_set = {state_q == CBMC_ST_RUN && exit_met,
        state_q == CBMC_ST_CHECK && health_fail && !mode_wr, blocked};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_q <= 3'b000;
            mask_q <= 3'b000;
        end else begin
            ev_q <= ev_set | (ev_q & ~(wr_evs ? wval[2:0] : 3'b000));
            if (wr_evm) begin
                mask_q <= wval[2:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ev_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////
    // read path
    logic [1:0] unit;
    logic [31:0] rd_mux;
    logic rd_ok;
    int idx;
    assign unit = is_auto ? {1'b0, mode_q[0]} : 2'b00;
    always_comb begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b1;
        idx = 0;
        case (axi_req.araddr)
            `CBMC_OFF_CTRL: rd_mux = {22'h0, unit, 3'h0, active, 1'b0, mode_q};
            `CBMC_OFF_STAT: rd_mux = {14'h0, alive_q, timer_q};
            `CBMC_OFF_UVSTAT: rd_mux = {31'h0, active};
            `CBMC_OFF_SECOND_STATUS_REG: rd_mux = {29'h0, ev_q};
            `CBMC_OFF_SWCTRL: rd_mux = {18'h0, sw_en_q};
            `CBMC_OFF_POLARITY: rd_mux = {18'h0, polarity_q};
            `CBMC_OFF_AUTOUV: rd_mux = {15'h0, min_cell_q, 2'h0, uv_thr_q};
            `CBMC_OFF_DLYCTRL: rd_mux = {16'h0, cal_dly_q, notify_q};
            `CBMC_OFF_EVSTAT: rd_mux = {29'h0, ev_q};
            `CBMC_OFF_EVMASK: rd_mux = {29'h0, mask_q};
            `CBMC_OFF_EXIT: rd_mux = {29'h0, exit_en_q};
            default: begin
                if (axi_req.araddr >= `CBMC_OFF_EXP1 && axi_req.araddr < `CBMC_OFF_EXP1 + 12'(NCELL * 4)
                    && axi_req.araddr[1:0] == 2'b00) begin
                    idx = int'((axi_req.araddr - `CBMC_OFF_EXP1) >> 2);
                    rd_mux = {22'h0, exp_q[idx]};
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'b00;
        end else if (axi_req.arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? 2'b00 : 2'b10;
        end else if (axi_req.rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

/* File: test/cbmc_assertions.sv */
module cbmc_assertions #(
    parameter int NCELL = 14,
    parameter int TICK_CYCLES = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire cbmc_pkg::cbmc_axi_req_type axi_req,
    input wire cbmc_pkg::cbmc_axi_rsp_type axi_rsp,
    input wire logic timer_expired,
    input wire logic thermal_fault,
    input wire logic uv_reached,
    input wire logic health_fail,
    input wire logic [NCELL-1:0] balance_switch_on,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import cbmc_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence all_exits;
        (timer_expired && thermal_fault && uv_reached && !axi_rsp.bvalid) [*8];
    endsequence
    ////////////////////////////////////////
    reset_idle_a: assert property ($rose(aresetn) |-> !axi_rsp.bvalid && !axi_rsp.rvalid && !irq
        && balance_switch_on == '0) else $error("outputs busy after reset");
    write_answer_a: assert property (wr_taken |-> ##[1:2] axi_rsp.bvalid)
        else $error("write not answered");
    bresp_legal_a: assert property (axi_rsp.bvalid |-> axi_rsp.bresp inside {2'b00, 2'b10})
        else $error("bad write response");
    bvalid_drop_a: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
        else $error("write response repeated");
    write_refused_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
        else $error("write taken while answering");
    read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |-> ##[1:2] axi_rsp.rvalid)
        else $error("read not answered");
    rvalid_drop_a: assert property (axi_rsp.rvalid && axi_req.rready |=> $fell(axi_rsp.rvalid))
        else $error("read response repeated");
    read_refused_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("read taken while answering");
    slverr_zero_a: assert property (axi_rsp.rvalid && axi_rsp.rresp == 2'b10 |-> axi_rsp.rdata == '0)
        else $error("error read carries data");
    exit_ends_a: assert property (all_exits |-> balance_switch_on == '0)
        else $error("switches on after exit");
endmodule
bind cbmc_top cbmc_assertions #(.NCELL(NCELL), .TICK_CYCLES(TICK_CYCLES)) cbmc_assertions_inst (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .timer_expired(timer_expired), .thermal_fault(thermal_fault), .uv_reached(uv_reached),
    .health_fail(health_fail), .balance_switch_on(balance_switch_on), .irq(irq));

/* File: test/cbmc_top_tb.sv */
`include "cbmc_regs.svh"
`define CBMC_CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end
module cbmc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cbmc_pkg::*;
    typedef struct packed {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} cbmc_exp_type;
    logic aclk = 0, aresetn = 0, timer_expired = 0, thermal_fault = 0, uv_reached = 0, health_fail = 0;
    cbmc_axi_req_type axi_req = '0;
    cbmc_axi_rsp_type axi_rsp;
    logic [13:0] balance_switch_on;
    logic irq;
    int n_errors = 0, tests_run = 0, cls;
    logic [15:0] lfsr_q = 16'hDC38;
    logic [31:0] d, last_rd;
    cbmc_exp_type exp_q[$], exp_e;
    logic [31:0] shadow [6];
    logic [11:0] cfg_addr [6] = '{`CBMC_OFF_SWCTRL, `CBMC_OFF_EXP1, `CBMC_OFF_EXPN, `CBMC_OFF_AUTOUV,
        `CBMC_OFF_DLYCTRL, `CBMC_OFF_POLARITY};
    logic [31:0] cfg_mask [6] = '{32'h3FFF, 32'h3FF, 32'h3FF, 32'h13FFF, 32'hFFFF, 32'h3FFF};
    // blocked in {auto, manual, emergency}
    logic [2:0] blk [6] = '{3'b100, 3'b111, 3'b100, 3'b100, 3'b101, 3'b000};
    always #2.5 aclk = ~aclk;
    cbmc_top #(.NCELL(14), .TICK_CYCLES(8)) cbmc_top_inst (.aclk(aclk), .aresetn(aresetn),
        .axi_req(axi_req), .axi_rsp(axi_rsp), .timer_expired(timer_expired), .thermal_fault(thermal_fault),
        .uv_reached(uv_reached), .health_fail(health_fail), .balance_switch_on(balance_switch_on), .irq(irq));
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return {lfsr_q, lfsr_q};
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r = 2'b00);
        logic aw_done;
        logic w_done;
        exp_q.push_back('{r, 32'h0, 32'h0});
        aw_done = 1'b0;
        w_done = 1'b0;
        axi_req.awaddr <= a;
        axi_req.wdata <= v;
        axi_req.wstrb <= 4'hF;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        // each channel released at its own handshake
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && axi_rsp.awready) begin
                aw_done = 1'b1;
                axi_req.awvalid <= 1'b0;
            end
            if (!w_done && axi_rsp.wready) begin
                w_done = 1'b1;
                axi_req.wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!axi_rsp.bvalid);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r = 2'b00);
        exp_q.push_back('{r, e & m, m});
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        do @(posedge aclk); while (!axi_rsp.arready);
        axi_req.arvalid <= 1'b0;
        do @(posedge aclk); while (!axi_rsp.rvalid);
        last_rd = axi_rsp.rdata;
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////
    // scoreboard: bready and rready stay high, so every valid is a handshake
    always @(posedge aclk) begin
        if (aresetn && (axi_rsp.bvalid || axi_rsp.rvalid)) begin
            exp_e = exp_q.pop_front();
            `CBMC_CHK(axi_rsp.bvalid ? axi_rsp.bresp : axi_rsp.rresp, exp_e.resp)
            `CBMC_CHK(axi_rsp.rdata & exp_e.mask, exp_e.data)
        end
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        complete_run();
    end
    initial begin
        axi_req.bready <= 1'b1;
        axi_req.rready <= 1'b1;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`CBMC_OFF_CTRL, 32'h0, 32'h1F);
        rd(`CBMC_OFF_EXIT, 32'h7, 32'h7);
        rd(12'hFFC, 32'h0, 32'hFFFFFFFF, 2'b10);
        wr(12'hFFC, rnd(), 2'b10);
        foreach (cfg_addr[i]) begin
            shadow[i] = rnd() & cfg_mask[i];
            wr(cfg_addr[i], shadow[i]);
            rd(cfg_addr[i], shadow[i], cfg_mask[i]);
        end
        rd(`CBMC_OFF_SECOND_STATUS_REG, 32'h0, 32'h1);
        for (int m = 1; m < 8; m++) begin
            cls = m[2] ? 2 : m[1];
            wr(`CBMC_OFF_CTRL, m);
            repeat (8) @(posedge aclk);
            rd(`CBMC_OFF_CTRL, m | 32'h10 | (m == 5 ? 32'h100 : 32'h0), m[2:1] == 2'b10 ? 32'h31F : 32'h1F);
            rd(`CBMC_OFF_UVSTAT, 32'h1, 32'h1);
            foreach (cfg_addr[i]) begin
                d = (rnd() & cfg_mask[i]) | (i == 0 ? 32'h10000 : 32'h0);
                wr(cfg_addr[i], d);
                if (!blk[i][cls]) shadow[i] = d & cfg_mask[i];
                rd(cfg_addr[i], shadow[i], cfg_mask[i]);
                rd(`CBMC_OFF_SECOND_STATUS_REG, {31'h0, blk[i][cls]}, 32'h1);
                wr(`CBMC_OFF_EVSTAT, 32'h1);
            end
            if (!m[2]) `CBMC_CHK(balance_switch_on, m[1] ? shadow[0][13:0] : 14'h0)
        end
        wr(`CBMC_OFF_CTRL, 32'h2);
        repeat (40) @(posedge aclk);
        rd(`CBMC_OFF_STAT, 32'h0, 32'h0);
        `CBMC_CHK(last_rd[15:0] inside {[16'h3:16'h6]}, 1'b1)
        `CBMC_CHK(last_rd[17:16], last_rd[1:0])
        wr(`CBMC_OFF_SWCTRL, 32'h10000 | shadow[0]);
        rd(`CBMC_OFF_STAT, 32'h0, 32'h0);
        `CBMC_CHK(last_rd[15:0] < 16'h2, 1'b1)
        wr(`CBMC_OFF_CTRL, 32'h4);
        repeat (8) @(posedge aclk);
        wr(`CBMC_OFF_EVMASK, 32'h4);
        timer_expired <= 1'b1;
        thermal_fault <= 1'b1;
        repeat (12) @(posedge aclk);
        rd(`CBMC_OFF_CTRL, 32'h14, 32'h1F);
        uv_reached <= 1'b1;
        repeat (12) @(posedge aclk);
        rd(`CBMC_OFF_CTRL, 32'h4, 32'h1F);
        rd(`CBMC_OFF_SECOND_STATUS_REG, 32'h4, 32'h4);
        `CBMC_CHK(irq, 1'b1)
        rd(`CBMC_OFF_STAT, 32'h0, 32'h0);
        `CBMC_CHK(last_rd[15:0] != 16'h0, 1'b1)
        timer_expired <= 1'b0;
        thermal_fault <= 1'b0;
        uv_reached <= 1'b0;
        wr(`CBMC_OFF_EVMASK, 32'h0);
        repeat (2) @(posedge aclk);
        `CBMC_CHK(irq, 1'b0)
        wr(`CBMC_OFF_EVMASK, 32'h4);
        repeat (2) @(posedge aclk);
        `CBMC_CHK(irq, 1'b1)
        wr(`CBMC_OFF_EVSTAT, 32'h4);
        repeat (2) @(posedge aclk);
        `CBMC_CHK(irq, 1'b0)
        wr(`CBMC_OFF_CTRL, 32'h0);
        rd(`CBMC_OFF_STAT, 32'h0, 32'h3FFFF);
        rd(`CBMC_OFF_CTRL, 32'h0, 32'h1F);
        health_fail <= 1'b1;
        wr(`CBMC_OFF_CTRL, 32'h2);
        repeat (8) @(posedge aclk);
        rd(`CBMC_OFF_SECOND_STATUS_REG, 32'h2, 32'h2);
        rd(`CBMC_OFF_CTRL, 32'h2, 32'h1F);
        `CBMC_CHK(balance_switch_on, 14'h0)
        health_fail <= 1'b0;
        repeat (4) @(posedge aclk);
        complete_run();
    end
endmodule
